// ==== src/appw_regs.svh ====
`ifndef APPW_REGS_SVH
`define APPW_REGS_SVH
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 20 MHz clock, AHB-Lite word registers
// Notes: offsets are byte addresses
`define APPW_CLK_MHZ 20
`define APPW_ADDR_CTRL 8'h00
`define APPW_ADDR_TIME 8'h04
`define APPW_ADDR_MEAS 8'h08
`define APPW_ADDR_STAT 8'h0C
`define APPW_ADDR_CMD 8'h10
`define APPW_ADDR_SAMPLE 8'h14
`define APPW_ADDR_RES 8'h40
`define APPW_ADDR_RAW 8'h80
`define APPW_ADDR_FILT 8'hC0
`define APPW_ADDR_SUM 8'h3C
// Control register fields
`define APPW_F_OVS 0
`define APPW_F_NOTCH 4
`define APPW_F_COEF 8
`define APPW_F_UPD 12
`define APPW_F_RDF 13
`define APPW_F_DBL 14
`define APPW_F_CAL 15
`define APPW_F_SINIT 16
`define APPW_F_BINIT 17
`define APPW_F_DBS 18
`define APPW_F_ALT 19
`define APPW_CTRL_RST 32'h0000_0200
// Watchdog base in microseconds
`define APPW_WD_BASE_US 750
// Notch cycle periods in microseconds
`define APPW_NOTCH50_US 625
`define APPW_NOTCH60_US 520
`define APPW_GAP_CYC 16'h0004
`endif

// ==== src/appw_pkg.sv ====
// Purpose: types for the acquisition post-processing block
// Assumes: none
// Notes: types only
package appw_pkg;
  typedef enum logic [1:0] {
    APPW_IDLE = 2'b00,
    APPW_RUN = 2'b01,
    APPW_WAIT = 2'b10
  } appw_state_t;
  typedef logic [15:0] appw_sample_t;
endpackage

// ==== src/appw_core.sv ====
// Purpose: comparator voting, acquisition watchdog, notch pacing and IIR filter
// Assumes: samples arrive from sequencer logic on the same clock
// Notes: registers reached over AHB-Lite
// Functional notes
// - Comparator alert when fault count meets threshold
// - Oversample code selects samples and watchdog limit
// - Timeout sets flag, resets converter, clears data
// - Double buffer timeout keeps results, next move
// - Watchdog lengthened by path delay, settle time
// - Notch off runs cycles back to back
// - Notch code selects 50/100 or 60/120 Hz
// - Notch fixes cycle period 625 or 520 us
// - Calibration correction applied when enabled
// - Filter only acts on enabled channels
// - Cell sum computed from selected data
// - Balancing forces filter, code 7 becomes 0
// - Output blends sample and history by FC
// - Coefficient codes map to eighths 1..8
// - Code 7 passes samples straight through
// - Update disabled leaves filter memory unchanged
// - Update enable steers data into accumulator
// - Readback select picks filtered or raw results
// - Init option loads next sample directly
// - Filter updated at end of scan, or at next start or move in double buffer
// - Single buffer loads filter at sequence end
`timescale 1ns/1ps
`include "appw_regs.svh"
module appw_core
  import appw_pkg::*;
#(
  parameter int NCH = 16,
  parameter int WD_SCALE = 1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Sequencer side
  input wire logic sample_valid_i,
  input wire logic [15:0] sample_i,
  input wire logic [3:0] sample_ch_i,
  input wire logic comp_fault_i,
  input wire logic cycle_done_i,
  input wire logic acq_done_i,
  input wire logic balance_mode_i,
  // Outputs to sequencer
  output logic acq_active_o,
  output logic cycle_start_o,
  output logic conv_reset_o,
  output logic comp_alert_o
);
  // ****************************************
  // Register state
  // ****************************************
  logic [31:0] ctrl_reg;
  logic [31:0] time_reg;
  logic [15:0] meas_reg;
  logic [15:0] cal_off_reg;
  logic timeout_reg;
  logic alert_reg;
  appw_state_t state_reg;
  appw_sample_t alu_reg [NCH];
  appw_sample_t filt_reg [NCH];
  appw_sample_t res_reg [NCH];
  logic [NCH-1:0] init_done_reg;
  logic [7:0] fault_cnt_reg;
  logic [31:0] wd_cnt_reg;
  logic [15:0] pace_cnt_reg;
  logic pend_move_reg;
  logic a_phase_reg;
  logic a_write_reg;
  logic [7:0] a_addr_reg;
  logic start_pulse;
  logic move_pulse;
  logic [2:0] ovs;
  logic [1:0] notch;
  logic [2:0] coef_eff;
  logic upd_en;
  logic [31:0] wd_limit;
  logic [15:0] pace_limit;
  logic [15:0] cal_sample;
  logic [19:0] cell_sum;

  assign ovs = ctrl_reg[`APPW_F_OVS +: 3];
  assign notch = ctrl_reg[`APPW_F_NOTCH +: 2];
  // Balancing forces update on and code 7 to code 0
  assign upd_en = ctrl_reg[`APPW_F_UPD] | balance_mode_i;
  assign coef_eff = (balance_mode_i && ctrl_reg[`APPW_F_COEF +: 3] == 3'h7) ? 3'h0
                    : ctrl_reg[`APPW_F_COEF +: 3];

  // ****************************************
  // Decode helpers
  // ****************************************
  // Oversample code to sample count: 1, then powers of two from 4 up to 128
  function automatic logic [7:0] ovs_count(input logic [2:0] c);
    ovs_count = (c == 3'h0) ? 8'h01 : (c >= 3'h6) ? 8'h80 : 8'h01 << (c + 3'h1);
  endfunction
  // Oversample code to fault vote threshold
  function automatic logic [7:0] vote_need(input logic [2:0] c);
    case (c)
      3'h0: vote_need = 8'h01;
      3'h1: vote_need = 8'h01;
      3'h2: vote_need = 8'h02;
      3'h3: vote_need = 8'h03;
      3'h4: vote_need = 8'h05;
      3'h5: vote_need = 8'h0A;
      default: vote_need = 8'h14;
    endcase
  endfunction
  // IIR blend with FC = (code+1)/8
  function automatic logic [15:0] iir(input logic [15:0] x, input logic [15:0] y, input logic [2:0] c);
    logic [19:0] acc;
    acc = 20'(x) * 20'({1'b0, c} + 4'h1) + 20'(y) * 20'(4'h7 - {1'b0, c});
    iir = acc[18:3];
  endfunction

  // Base limit 750 us, 3000 us at code 1, then doubling per code step; extensions added in microseconds
  logic [31:0] wd_us;
  always_comb begin
    wd_us = (ovs == 3'h0) ? 32'(`APPW_WD_BASE_US) : 32'(3000) << (ovs - 3'h1);
    wd_us = wd_us + (ctrl_reg[`APPW_F_DBS] ? 32'(time_reg[15:0]) : 32'h0);
    wd_us = wd_us + 32'(time_reg[25:16]) * 32'h6;
    wd_limit = wd_us * 32'(`APPW_CLK_MHZ) / 32'(WD_SCALE);
  end
  // Per-cycle period: notch fixes it, else minimal recharge gap
  always_comb begin
    case (notch)
      2'b00: pace_limit = `APPW_GAP_CYC;
      2'b01: pace_limit = 16'(`APPW_NOTCH50_US * `APPW_CLK_MHZ);
      default: pace_limit = 16'(`APPW_NOTCH60_US * `APPW_CLK_MHZ);
    endcase
  end
  // Calibration offset correction on the way to the ALU
  assign cal_sample = ctrl_reg[`APPW_F_CAL] ? sample_i - cal_off_reg : sample_i;

  // ****************************************
  // AHB-Lite slave, zero wait states
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      a_phase_reg <= 1'b0;
      a_write_reg <= 1'b0;
      a_addr_reg <= 8'h00;
    end else if (hready_i) begin
      a_phase_reg <= hsel_i & htrans_i[1];
      a_write_reg <= hwrite_i;
      a_addr_reg <= haddr_i[7:0];
    end
  end
  assign start_pulse = a_phase_reg & a_write_reg & (a_addr_reg == `APPW_ADDR_CMD) & hwdata_i[0];
  assign move_pulse = a_phase_reg & a_write_reg & (a_addr_reg == `APPW_ADDR_CMD) & hwdata_i[1];
  // Config register writes
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ctrl_reg <= `APPW_CTRL_RST;
      time_reg <= 32'h0000_0000;
      meas_reg <= 16'hFFFF;
      cal_off_reg <= 16'h0000;
    end else if (a_phase_reg && a_write_reg) begin
      case (a_addr_reg)
        `APPW_ADDR_CTRL: ctrl_reg <= hwdata_i;
        `APPW_ADDR_TIME: time_reg <= hwdata_i;
        `APPW_ADDR_MEAS: meas_reg <= hwdata_i[15:0];
        `APPW_ADDR_SAMPLE: cal_off_reg <= hwdata_i[15:0];
        default: ;
      endcase
    end
  end
  // Cell sum from the selected result set
  always_comb begin
    cell_sum = 20'h0;
    for (int i = 0; i < NCH; i++) begin
      cell_sum = cell_sum + 20'(res_reg[i]);
    end
  end
  // Read data mux registered for the data phase
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
      case (haddr_i[7:6])
        2'h1: hrdata_o <= 32'(res_reg[haddr_i[5:2]]);
        2'h2: hrdata_o <= 32'(alu_reg[haddr_i[5:2]]);
        2'h3: hrdata_o <= 32'(filt_reg[haddr_i[5:2]]);
        default: begin
          case (haddr_i[7:0])
            `APPW_ADDR_CTRL: hrdata_o <= ctrl_reg;
            `APPW_ADDR_TIME: hrdata_o <= time_reg;
            `APPW_ADDR_MEAS: hrdata_o <= 32'(meas_reg);
            `APPW_ADDR_STAT: hrdata_o <= {28'h0, state_reg, alert_reg, timeout_reg};
            `APPW_ADDR_SAMPLE: hrdata_o <= 32'(cal_off_reg);
            `APPW_ADDR_SUM: hrdata_o <= 32'(cell_sum);
            default: hrdata_o <= 32'h0000_0000;
          endcase
        end
      endcase
    end
  end
  // Zero wait states and always OKAY, in and out of reset
  always_ff @(posedge clock_i) begin
    hreadyout_o <= 1'b1;
    hresp_o <= 1'b0;
  end

  // ****************************************
  // Acquisition sequencing and watchdog
  // ****************************************
  logic wd_expire;
  assign wd_expire = (state_reg != APPW_IDLE) && (wd_cnt_reg >= wd_limit - 32'h1);
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_reg <= APPW_IDLE;
      wd_cnt_reg <= 32'h0;
      pace_cnt_reg <= 16'h0;
      cycle_start_o <= 1'b0;
      acq_active_o <= 1'b0;
      conv_reset_o <= 1'b0;
    end else begin
      cycle_start_o <= 1'b0;
      conv_reset_o <= 1'b0;
      case (state_reg)
        APPW_IDLE: begin
          wd_cnt_reg <= 32'h0;
          if (start_pulse) begin
            state_reg <= APPW_RUN;
            acq_active_o <= 1'b1;
            cycle_start_o <= 1'b1;
            pace_cnt_reg <= 16'h0;
          end
        end
        APPW_RUN, APPW_WAIT: begin
          wd_cnt_reg <= wd_cnt_reg + 32'h1;
          pace_cnt_reg <= pace_cnt_reg + 16'h1;
          if (wd_expire) begin
            state_reg <= APPW_IDLE;
            acq_active_o <= 1'b0;
            conv_reset_o <= 1'b1;
          end else if (acq_done_i) begin
            state_reg <= APPW_IDLE;
            acq_active_o <= 1'b0;
          end else if (cycle_done_i) begin
            state_reg <= APPW_WAIT;
          end else if (state_reg == APPW_WAIT && pace_cnt_reg >= pace_limit - 16'h1) begin
            state_reg <= APPW_RUN;
            pace_cnt_reg <= 16'h0;
            cycle_start_o <= 1'b1;
          end
        end
        default: state_reg <= APPW_IDLE;
      endcase
    end
  end
  // Sticky timeout flag, cleared by writing bit 0 of status; set wins
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      timeout_reg <= 1'b0;
    end else if (wd_expire) begin
      timeout_reg <= 1'b1;
    end else if (a_phase_reg && a_write_reg && a_addr_reg == `APPW_ADDR_STAT && hwdata_i[0]) begin
      timeout_reg <= 1'b0;
    end
  end

  // ****************************************
  // Comparator voting
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      fault_cnt_reg <= 8'h0;
      alert_reg <= 1'b0;
      comp_alert_o <= 1'b0;
    end else begin
      if (start_pulse && state_reg == APPW_IDLE) begin
        fault_cnt_reg <= 8'h0;
        alert_reg <= 1'b0;
      end else if (sample_valid_i && comp_fault_i && fault_cnt_reg < ovs_count(ovs)) begin
        fault_cnt_reg <= fault_cnt_reg + 8'h1;
      end
      if (acq_done_i && state_reg != APPW_IDLE) begin
        alert_reg <= fault_cnt_reg >= vote_need(ovs);
      end
      comp_alert_o <= alert_reg;
    end
  end

  // ****************************************
  // ALU, IIR accumulator and result registers
  // ****************************************
  // Normal end strobe and filter reload request
  logic load_end;
  logic init_req;
  assign load_end = acq_done_i && state_reg != APPW_IDLE && !wd_expire;
  assign init_req = ctrl_reg[`APPW_F_SINIT] || (balance_mode_i && ctrl_reg[`APPW_F_BINIT]);
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pend_move_reg <= 1'b0;
    end else if (load_end || wd_expire) begin
      pend_move_reg <= ctrl_reg[`APPW_F_DBL];
    end else if (start_pulse || move_pulse) begin
      pend_move_reg <= 1'b0;
    end
  end
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_ch
      logic ch_en;
      logic xfer;
      logic [15:0] new_filt;
      assign ch_en = meas_reg[g];
      // Filter loads at sequence end in single buffer, next start or move command in double
      assign xfer = ch_en && upd_en &&
                    ((load_end && !ctrl_reg[`APPW_F_DBL]) || (pend_move_reg && (start_pulse || move_pulse)));
      assign new_filt = (init_req || !init_done_reg[g]) ? alu_reg[g]
                        : (coef_eff == 3'h7) ? alu_reg[g]
                        : iir(alu_reg[g], filt_reg[g], coef_eff);
      // Sequencer ALU capture
      always_ff @(posedge clock_i) begin
        if (reset_i || wd_expire) begin
          alu_reg[g] <= 16'h0000;
        end else if (sample_valid_i && sample_ch_i == 4'(g) && ch_en) begin
          alu_reg[g] <= cal_sample;
        end
      end
      // Filter memory untouched unless update enabled
      always_ff @(posedge clock_i) begin
        if (reset_i) begin
          filt_reg[g] <= 16'h0000;
          init_done_reg[g] <= 1'b0;
        end else if (xfer) begin
          filt_reg[g] <= new_filt;
          init_done_reg[g] <= 1'b1;
        end
      end
      // Result register load: raw or filtered
      always_ff @(posedge clock_i) begin
        if (reset_i) begin
          res_reg[g] <= 16'h0000;
        end else if (wd_expire && !ctrl_reg[`APPW_F_DBL]) begin
          res_reg[g] <= 16'h0000;
        end else if ((load_end && !ctrl_reg[`APPW_F_DBL]) || (pend_move_reg && (start_pulse || move_pulse))) begin
          res_reg[g] <= (ctrl_reg[`APPW_F_RDF] && ch_en && upd_en) ? new_filt
                        : ctrl_reg[`APPW_F_RDF] ? filt_reg[g] : alu_reg[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Assertions
  // ****************************************
  property p_timeout_set;
    @(posedge clock_i) disable iff (reset_i) wd_expire |=> timeout_reg && state_reg == APPW_IDLE;
  endproperty
  a_timeout_set: assert property (p_timeout_set) else $error("timeout flag not set");
  property p_conv_reset;
    @(posedge clock_i) disable iff (reset_i) wd_expire |=> conv_reset_o && !acq_active_o;
  endproperty
  a_conv_reset: assert property (p_conv_reset) else $error("converter not reset");
  property p_alu_clear;
    @(posedge clock_i) disable iff (reset_i) wd_expire |=> alu_reg[0] == 16'h0000;
  endproperty
  a_alu_clear: assert property (p_alu_clear) else $error("ALU not cleared");
  property p_dbl_keep;
    @(posedge clock_i) disable iff (reset_i) wd_expire && ctrl_reg[`APPW_F_DBL] |=> $stable(res_reg[0]);
  endproperty
  a_dbl_keep: assert property (p_dbl_keep) else $error("double buffer result changed");
  property p_wd_idle;
    @(posedge clock_i) disable iff (reset_i) state_reg == APPW_IDLE ##1 state_reg == APPW_IDLE |-> wd_cnt_reg == 32'h0;
  endproperty
  a_wd_idle: assert property (p_wd_idle) else $error("watchdog runs while idle");
  property p_filt_hold;
    @(posedge clock_i) disable iff (reset_i) !upd_en |=> $stable(filt_reg[0]);
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filter memory changed");
  property p_alert_vote;
    @(posedge clock_i) disable iff (reset_i)
      acq_done_i && state_reg != APPW_IDLE |=> alert_reg == ($past(fault_cnt_reg) >= vote_need($past(ovs)));
  endproperty
  a_alert_vote: assert property (p_alert_vote) else $error("alert vote wrong");
  property p_bal_coef;
    @(posedge clock_i) disable iff (reset_i) balance_mode_i |-> coef_eff != 3'h7 && upd_en;
  endproperty
  a_bal_coef: assert property (p_bal_coef) else $error("balance coefficient not forced");
endmodule

// ==== verification/appw_seq_model.sv ====
// Purpose: behavioural sequencer feeding samples and cycle events to the core
// Assumes: one sample per channel a cycle, channel 0 first
// Notes: sample bus shows a changing pattern outside its valid cycle while active, and holds 5A5A while idle
`timescale 1ns/1ps
module appw_seq_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Core handshake
  input wire logic acq_active_i,
  input wire logic cycle_start_i,
  // Scenario controls
  input wire logic mute_i,
  input wire logic [3:0] nch_i,
  input wire logic [7:0] ncyc_i,
  input wire logic [7:0] nfault_i,
  input wire logic [15:0] base_i,
  // Sample stream
  output logic sample_valid_o,
  output logic [15:0] sample_o,
  output logic [3:0] ch_o,
  output logic comp_fault_o,
  output logic cycle_done_o,
  output logic acq_done_o
);
  logic busy_reg;
  logic [3:0] idx_reg;
  logic [7:0] cyc_reg;
  // Channel walk, then cycle end, with acquisition end in the same cycle on the last cycle
  always_ff @(posedge clock_i) begin
    sample_valid_o <= 1'b0;
    cycle_done_o <= 1'b0;
    acq_done_o <= 1'b0;
    comp_fault_o <= 1'b0;
    sample_o <= ~sample_o;
    ch_o <= ~ch_o;
    if (reset_i || !acq_active_i) begin
      busy_reg <= 1'b0;
      idx_reg <= 4'h0;
      cyc_reg <= 8'h00;
      sample_o <= 16'h5A5A;
      ch_o <= 4'h5;
    end else if (cycle_start_i && !mute_i) begin
      busy_reg <= 1'b1;
      idx_reg <= 4'h0;
    end else if (busy_reg && idx_reg < nch_i) begin
      sample_valid_o <= 1'b1;
      sample_o <= base_i + 16'(idx_reg);
      ch_o <= idx_reg;
      comp_fault_o <= (idx_reg == 4'h0) && (cyc_reg < nfault_i);
      idx_reg <= idx_reg + 4'h1;
    end else if (busy_reg) begin
      busy_reg <= 1'b0;
      cycle_done_o <= 1'b1;
      cyc_reg <= cyc_reg + 8'h01;
      acq_done_o <= (cyc_reg + 8'h01 == ncyc_i);
    end
  end
endmodule

// ==== verification/tb_appw_core.sv ====
// Purpose: self-checking bench for the post-processing core
// Assumes: model sequencer, watchdog counts at full scale
// Notes: bus master holds each phase until hready
`timescale 1ns/1ps
`include "appw_regs.svh"
module tb_appw_core
  import appw_pkg::*;
;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic hreadyout_o, hresp_o, sample_valid_i, comp_fault_i, cycle_done_i, acq_done_i;
  logic acq_active_o, cycle_start_o, conv_reset_o, comp_alert_o;
  logic [15:0] sample_i;
  logic [3:0] sample_ch_i;
  logic balance_mode = 1'b0;
  logic mute = 1'b0;
  logic [7:0] ncyc = 8'h01;
  logic [7:0] nfault = 8'h00;
  appw_sample_t base = 16'h0;
  int n_errors = 0;
  int cmp_count = 0;
  // ***************************
  // Clock, design and sequencer
  // ***************************
  always #25 clock_i = ~clock_i;
  appw_core #(.NCH(16), .WD_SCALE(1)) dut (.clock_i(clock_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .sample_valid_i(sample_valid_i),
    .sample_i(sample_i), .sample_ch_i(sample_ch_i), .comp_fault_i(comp_fault_i), .cycle_done_i(cycle_done_i),
    .acq_done_i(acq_done_i), .balance_mode_i(balance_mode), .acq_active_o(acq_active_o),
    .cycle_start_o(cycle_start_o), .conv_reset_o(conv_reset_o), .comp_alert_o(comp_alert_o));
  appw_seq_model seq (.clock_i(clock_i), .reset_i(reset_i), .acq_active_i(acq_active_o), .cycle_start_i(cycle_start_o),
    .mute_i(mute), .nch_i(4'h5), .ncyc_i(ncyc), .nfault_i(nfault), .base_i(base), .sample_valid_o(sample_valid_i),
    .sample_o(sample_i), .ch_o(sample_ch_i), .comp_fault_o(comp_fault_i), .cycle_done_o(cycle_done_i),
    .acq_done_o(acq_done_i));
  // ***************************
  // Shared tasks
  // ***************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= wr;
    @(posedge clock_i);
    while (hreadyout_o !== 1'b1) @(posedge clock_i);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    @(posedge clock_i);
    while (hreadyout_o !== 1'b1) @(posedge clock_i);
    rd = hrdata_o;
    chk("hresp", 32'h0, {31'h0, hresp_o});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(what, exp, d & m);
  endtask
  function automatic logic [31:0] cw(input int ov, input int nt, input int fc, input int up, input int rf, input int si);
    return 32'((ov << `APPW_F_OVS) | (nt << `APPW_F_NOTCH) | (fc << `APPW_F_COEF) | (up << `APPW_F_UPD)
      | (rf << `APPW_F_RDF) | (si << `APPW_F_SINIT));
  endfunction
  task automatic wait_end();
    for (int i = 0; i < 40000 && acq_active_o === 1'b1; i++) @(posedge clock_i);
    chk("acquisition end", 32'h0, {31'h0, acq_active_o});
  endtask
  task automatic acquire(input logic [31:0] ctl, input appw_sample_t b);
    base <= b;
    wr(`APPW_ADDR_CTRL, ctl);
    wr(`APPW_ADDR_CMD, 32'h1);
    repeat (2) @(posedge clock_i);
    wait_end();
  endtask
  // ***************************
  // Scenarios
  // ***************************
  task automatic t_reset();
    rdm(`APPW_ADDR_CTRL, '1, `APPW_CTRL_RST, "ctrl reset");
    rdm(`APPW_ADDR_MEAS, '1, 32'h0000FFFF, "meas reset");
    rdm(`APPW_ADDR_STAT, '1, 32'h0, "stat reset");
    wr(8'h30, 32'hFFFFFFFF);
    rdm(8'h30, '1, 32'h0, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_filter();
    int y;
    int x;
    ncyc <= 8'h01;
    wr(`APPW_ADDR_MEAS, 32'h0000000F);
    acquire(cw(0, 0, 2, 1, 1, 1), 16'h1000);
    rdm(`APPW_ADDR_FILT, '1, 32'h1000, "filter init");
    rdm(`APPW_ADDR_FILT + 8'h10, '1, 32'h0, "filter disabled ch");
    y = 32'h1000;
    for (int c = 0; c < 8; c++) begin
      x = 32'h0800 + c * 32'h0300;
      acquire(cw(0, 0, c, 1, 1, 0), 16'(x));
      y = ((c + 1) * x + (7 - c) * y) / 8;
      rdm(`APPW_ADDR_FILT, '1, 32'(y), "filter blend");
      rdm(`APPW_ADDR_RES, '1, 32'(y), "filtered readback");
    end
    $display("test filter done");
  endtask
  task automatic t_bypass();
    acquire(cw(0, 0, 2, 0, 0, 0), 16'h2000);
    rdm(`APPW_ADDR_FILT, '1, 32'h1D00, "filter held");
    rdm(`APPW_ADDR_RES, '1, 32'h2000, "raw result");
    rdm(`APPW_ADDR_RES + 8'h0C, '1, 32'h2003, "raw result ch3");
    rdm(`APPW_ADDR_RAW, '1, 32'h2000, "alu uncorrected");
    rdm(`APPW_ADDR_SUM, '1, 32'h8006, "cell sum raw");
    wr(`APPW_ADDR_SAMPLE, 32'h0000_0100);
    acquire(cw(0, 0, 2, 0, 0, 0) | (32'h1 << `APPW_F_CAL), 16'h2000);
    rdm(`APPW_ADDR_RAW, '1, 32'h1F00, "alu corrected");
    balance_mode <= 1'b1;
    acquire(cw(0, 0, 7, 1, 1, 0), 16'h2500);
    rdm(`APPW_ADDR_FILT, '1, 32'h1E00, "balance coef");
    acquire(cw(0, 0, 2, 0, 1, 0) | (32'h1 << `APPW_F_BINIT), 16'h2600);
    balance_mode <= 1'b0;
    rdm(`APPW_ADDR_FILT, '1, 32'h2600, "balance init load");
    $display("test bypass and balance done");
  endtask
  task automatic t_alert();
    int ov[3] = '{6, 2, 2};
    int nf[3] = '{19, 1, 2};
    int nc[3] = '{128, 8, 8};
    for (int k = 0; k < 3; k++) begin
      ncyc <= 8'(nc[k]);
      nfault <= 8'(nf[k]);
      acquire(cw(ov[k], 0, 2, 0, 0, 0), 16'h1111);
      rdm(`APPW_ADDR_STAT, 32'h2, 32'(k / 2) << 1, "alert stat");
      chk("alert pin", 32'(k / 2), {31'h0, comp_alert_o});
    end
    nfault <= 8'h00;
    $display("test alert done");
  endtask
  task automatic t_pace(input int nt, input int lo, input int hi);
    int n;
    ncyc <= 8'h02;
    wr(`APPW_ADDR_CTRL, cw(1, nt, 2, 0, 0, 0));
    wr(`APPW_ADDR_CMD, 32'h1);
    for (n = 0; n < 100 && cycle_start_o !== 1'b1; n++) @(posedge clock_i);
    @(posedge clock_i);
    for (n = 1; n < 20000 && cycle_start_o !== 1'b1; n++) @(posedge clock_i);
    chk("pace gap in range", 32'h1, {31'h0, n >= lo && n <= hi});
    wait_end();
    rdm(`APPW_ADDR_STAT, 32'h1, 32'h0, "no timeout");
    $display("test pace done");
  endtask
  task automatic t_watch(input logic [31:0] tm, input logic [31:0] ctl, input int span, input logic [31:0] res);
    int n;
    mute <= 1'b1;
    wr(`APPW_ADDR_TIME, tm);
    wr(`APPW_ADDR_CTRL, ctl);
    wr(`APPW_ADDR_CMD, 32'h1);
    for (n = 0; n < 100 && acq_active_o !== 1'b1; n++) @(posedge clock_i);
    for (n = 0; n < 20000 && conv_reset_o !== 1'b1; n++) @(posedge clock_i);
    chk("watchdog span", 32'h1, {31'h0, n >= span - 2 && n <= span + 3});
    rdm(`APPW_ADDR_STAT, 32'h1, 32'h1, "timeout flag");
    rdm(`APPW_ADDR_RES, '1, res, "result after timeout");
    chk("acq stopped", 32'h0, {31'h0, acq_active_o});
    wr(`APPW_ADDR_STAT, 32'h1);
    rdm(`APPW_ADDR_STAT, 32'h1, 32'h0, "timeout cleared");
    mute <= 1'b0;
    $display("test watchdog done");
  endtask
  task automatic t_double();
    acquire(cw(0, 0, 2, 0, 0, 0), 16'h3000);
    t_watch(32'h00010002, cw(0, 0, 2, 0, 0, 0) | (32'h1 << `APPW_F_DBL) | (32'h1 << `APPW_F_DBS), 15160, 32'h3000);
    wr(`APPW_ADDR_CMD, 32'h2);
    rdm(`APPW_ADDR_RES, '1, 32'h0, "cleared alu moved");
    $display("test double buffer done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ***************************
  // Main sequence and watchdog
  // ***************************
  initial begin
    repeat (6) @(posedge clock_i);
    reset_i <= 1'b0;
    t_reset();
    t_filter();
    t_bypass();
    t_alert();
    t_pace(0, 5, 20);
    t_pace(1, 12495, 12515);
    t_pace(2, 10395, 10415);
    t_watch(32'h0, cw(0, 0, 2, 0, 0, 0), 15000, 32'h0);
    t_double();
    complete_run();
  end
  initial begin
    #4000000;
    n_errors++;
    $display("[FAIL] run time expected end seen hang");
    complete_run();
  end
endmodule
